/* File: include/arfm_pkg.sv */
// Shared constants and types for the result formatter and channel mux block
package arfm_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SAMPLE_W = 12;
    localparam int ACC_W = 19;
    localparam int RESULT_W = 16;
    localparam int MUX_W = 6;
    localparam int SEL_W = 3;
    localparam int TICK_W = 4;
    localparam int SCNT_W = 8;
    localparam int DIV_W = 8;
    localparam int ADC_DIV_DEFAULT = 8;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL_A = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_B = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_POS_SELECT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_NEG_SELECT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_INTFLAGS = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_INTMASK = 4'h7;

    localparam int CTRL_LEFT_ADJUST_BIT = 0;
    localparam int CTRL_DIFF_BIT = 1;
    localparam int CMD_START_BIT = 0;
    localparam int FLAG_READY_BIT = 0;

    localparam logic [SEL_W-1:0] SEL_ONE = 3'h0;
    localparam logic [SEL_W-1:0] SEL_TWO = 3'h1;
    localparam logic [SEL_W-1:0] SEL_FULL = 3'h4;
    localparam logic [SEL_W-1:0] SEL_MAX = 3'h7;

    localparam logic [TICK_W-1:0] LAST_TICK = 4'hF;
    localparam logic [MUX_W-1:0] NEG_NONE = 6'h00;
    localparam logic [MUX_W-1:0] MUX_RESET = 6'h00;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_ZERO = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [SCNT_W-1:0] SCNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        ARFM_IDLE,
        ARFM_STARTUP,
        ARFM_CONVERT,
        ARFM_DONE
    } arfm_state_t;
endpackage

/* File: rtl/arfm_format.sv */
// Result alignment, sign extension and truncation of the accumulated sum
module arfm_format
    import arfm_pkg::*;
(
    input wire logic [ACC_W-1:0] acc,
    input wire logic [SEL_W-1:0] count_sel,
    input wire logic left_adjust,
    input wire logic diff_mode,
    output wire logic [RESULT_W-1:0] result
);
    wire logic signed [ACC_W-1:0] acc_s = acc;
    wire logic fits = count_sel <= SEL_FULL;
    wire logic [SEL_W-1:0] down = fits ? SEL_ONE : SEL_W'(count_sel - SEL_FULL);
    wire logic [SEL_W-1:0] up = (fits && left_adjust) ? SEL_W'(SEL_FULL - count_sel) : SEL_ONE;
    wire logic [ACC_W-1:0] shr = diff_mode ? ACC_W'(acc_s >>> down) : ACC_W'(acc >> down);
    wire logic [ACC_W-1:0] shl = ACC_W'(shr << up);
    assign result = shl[RESULT_W-1:0];
endmodule

/* File: rtl/arfm_top.sv */
// Accumulating result formatter and buffered input selection of the converter
// Function
// - Without left adjust, result is right aligned, low bits in low byte.
// - With left adjust set, eight top result bits land in high byte.
// - Sum a programmed number of consecutive samples into one result.
// - Above sixteen samples, drop low sum bits to fit sixteen bits.
// - Single-ended: 12..16 low bits used; left adjust pads 4..0 zeros.
// - Differential: same widths, sign extended right, zero padded left.
// - For 32, 64, 128 samples store truncated full sixteen-bit sum.
// - Single-ended uses positive select only; differential uses both.
// - Input selects are held in a buffer, applied at safe points.
// - While idle, programmed selects copy to the active selects continuously.
// - Once converting, active selects freeze against software writes.
// - Updating resumes in the final converter tick of every accumulated sample.
// - A start write begins conversion on the next converter tick.
// - On completion store result and set the result ready flag.
// - Single-ended results unsigned; differential two's complement sign extended.
// - Start bit stays set until the last accumulated sample completes.
module arfm_top
    import arfm_pkg::*;
#(
    parameter int ADC_DIV = ADC_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [SAMPLE_W-1:0] core_sample_data,
    output logic [MUX_W-1:0] pos_select_active,
    output logic [MUX_W-1:0] neg_select_active,
    output logic diff_mode_active,
    output logic adc_tick_out,
    output logic converting,
    output logic irq
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    logic left_adjust_select_ff;
    logic diff_mode_ff;
    logic [SEL_W-1:0] accumulation_count_select_ff;
    logic [MUX_W-1:0] positive_input_select_ff;
    logic [MUX_W-1:0] negative_input_select_ff;
    logic start_conversion_bit_ff;
    logic [RESULT_W-1:0] conversion_result_ff;
    logic result_ready_flag_ff;
    logic result_ready_mask_ff;
    arfm_state_t state_ff;
    arfm_state_t nxt_state;
    logic [DIV_W-1:0] div_cnt_ff;
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [SCNT_W-1:0] samp_cnt_ff;
    logic [ACC_W-1:0] acc_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [MUX_W-1:0] pos_act_ff;
    logic [MUX_W-1:0] neg_act_ff;
    logic diff_act_ff;
    logic adc_tick_ff;
    logic converting_ff;
    logic irq_ff;
    logic nxt_flag;

    wire logic wr_control_a = reg_wr && reg_hit(reg_addr, ADDR_CONTROL_A);
    wire logic wr_control_b = reg_wr && reg_hit(reg_addr, ADDR_CONTROL_B);
    wire logic wr_pos_select = reg_wr && reg_hit(reg_addr, ADDR_POS_SELECT);
    wire logic wr_neg_select = reg_wr && reg_hit(reg_addr, ADDR_NEG_SELECT);
    wire logic wr_cmd = reg_wr && reg_hit(reg_addr, ADDR_COMMAND);
    wire logic wr_mask = reg_wr && reg_hit(reg_addr, ADDR_INTMASK);
    wire logic rd_flags = reg_rd && reg_hit(reg_addr, ADDR_INTFLAGS);

    // Prescaler held at zero while idle so the start delay is fixed
    wire logic adc_tick = (state_ff != ARFM_IDLE) && (div_cnt_ff == DIV_W'(ADC_DIV - 1));
    wire logic go = wr_cmd && reg_wdata[CMD_START_BIT] && (state_ff == ARFM_IDLE);
    wire logic in_conv = state_ff == ARFM_CONVERT;
    wire logic last_tick = in_conv && (tick_cnt_ff == LAST_TICK);
    wire logic sample_end = last_tick && adc_tick;
    wire logic [SCNT_W-1:0] samples_m1 = SCNT_W'((SCNT_ONE << accumulation_count_select_ff) - SCNT_ONE);
    wire logic final_sample = samp_cnt_ff == samples_m1;
    wire logic done = state_ff == ARFM_DONE;
    wire logic locked = in_conv && !last_tick;

    wire logic signed [SAMPLE_W-1:0] sample_s = core_sample_data;
    wire logic [ACC_W-1:0] sample_ext = diff_mode_ff ? ACC_W'(sample_s) : ACC_W'(core_sample_data);
    wire logic [RESULT_W-1:0] formatted;

    wire logic [DATA_W-1:0] rd_mux =
        reg_hit(reg_addr, ADDR_CONTROL_A) ? DATA_W'({diff_mode_ff, left_adjust_select_ff}) :
        reg_hit(reg_addr, ADDR_CONTROL_B) ? DATA_W'(accumulation_count_select_ff) :
        reg_hit(reg_addr, ADDR_POS_SELECT) ? DATA_W'(positive_input_select_ff) :
        reg_hit(reg_addr, ADDR_NEG_SELECT) ? DATA_W'(negative_input_select_ff) :
        reg_hit(reg_addr, ADDR_COMMAND) ? DATA_W'(start_conversion_bit_ff) :
        reg_hit(reg_addr, ADDR_RESULT) ? DATA_W'(conversion_result_ff) :
        reg_hit(reg_addr, ADDR_INTFLAGS) ? DATA_W'(result_ready_flag_ff) :
        reg_hit(reg_addr, ADDR_INTMASK) ? DATA_W'(result_ready_mask_ff) : DATA_ZERO;

    arfm_format u_format (
        .acc(acc_ff),
        .count_sel(accumulation_count_select_ff),
        .left_adjust(left_adjust_select_ff),
        .diff_mode(diff_mode_ff),
        .result(formatted)
    );

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ARFM_IDLE: begin
                if (go) begin
                    nxt_state = ARFM_STARTUP;
                end
            end
            ARFM_STARTUP: begin
                if (adc_tick) begin
                    nxt_state = ARFM_CONVERT;
                end
            end
            ARFM_CONVERT: begin
                if (sample_end && final_sample) begin
                    nxt_state = ARFM_DONE;
                end
            end
            ARFM_DONE: begin
                nxt_state = ARFM_IDLE;
            end
        endcase
    end

    // Event set wins over a clearing read
    assign nxt_flag = done || (result_ready_flag_ff && !rd_flags);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ARFM_IDLE;
            div_cnt_ff <= '0;
            tick_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            div_cnt_ff <= (state_ff == ARFM_IDLE || adc_tick) ? '0 : DIV_W'(div_cnt_ff + 1'h1);
            tick_cnt_ff <= !in_conv ? '0 : (adc_tick ? TICK_W'(tick_cnt_ff + 1'h1) : tick_cnt_ff);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_ff <= ACC_ZERO;
            samp_cnt_ff <= '0;
        end else if (go) begin
            acc_ff <= ACC_ZERO;
            samp_cnt_ff <= '0;
        end else if (sample_end) begin
            acc_ff <= ACC_W'(acc_ff + sample_ext);
            samp_cnt_ff <= SCNT_W'(samp_cnt_ff + 1'h1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            left_adjust_select_ff <= 1'h0;
            diff_mode_ff <= 1'h0;
            accumulation_count_select_ff <= SEL_RESET;
            positive_input_select_ff <= MUX_RESET;
            negative_input_select_ff <= MUX_RESET;
            result_ready_mask_ff <= 1'h0;
        end else begin
            if (wr_control_a) begin
                left_adjust_select_ff <= reg_wdata[CTRL_LEFT_ADJUST_BIT];
                diff_mode_ff <= reg_wdata[CTRL_DIFF_BIT];
            end
            if (wr_control_b) begin
                accumulation_count_select_ff <= reg_wdata[SEL_W-1:0];
            end
            if (wr_pos_select) begin
                positive_input_select_ff <= reg_wdata[MUX_W-1:0];
            end
            if (wr_neg_select) begin
                negative_input_select_ff <= reg_wdata[MUX_W-1:0];
            end
            if (wr_mask) begin
                result_ready_mask_ff <= reg_wdata[FLAG_READY_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_act_ff <= MUX_RESET;
            neg_act_ff <= NEG_NONE;
            diff_act_ff <= 1'h0;
        end else if (!locked) begin
            pos_act_ff <= positive_input_select_ff;
            neg_act_ff <= diff_mode_ff ? negative_input_select_ff : NEG_NONE;
            diff_act_ff <= diff_mode_ff;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_conversion_bit_ff <= 1'h0;
            conversion_result_ff <= RESULT_RESET;
            result_ready_flag_ff <= 1'h0;
        end else begin
            start_conversion_bit_ff <= go || (start_conversion_bit_ff && !done);
            result_ready_flag_ff <= nxt_flag;
            if (done) begin
                conversion_result_ff <= formatted;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= DATA_ZERO;
            adc_tick_ff <= 1'h0;
            converting_ff <= 1'h0;
            irq_ff <= 1'h0;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : DATA_ZERO;
            adc_tick_ff <= adc_tick;
            converting_ff <= nxt_state == ARFM_CONVERT;
            irq_ff <= nxt_flag && result_ready_mask_ff;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pos_select_active = pos_act_ff;
    assign neg_select_active = neg_act_ff;
    assign diff_mode_active = diff_act_ff;
    assign adc_tick_out = adc_tick_ff;
    assign converting = converting_ff;
    assign irq = irq_ff;

    // Checks on the block's own behaviour
    localparam int START_MAX = ADC_DIV + 1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    lock_hold_a: assert property (locked |=> $stable(pos_act_ff) && $stable(neg_act_ff))
        else $error("active select changed while locked");
    idle_copy_a: assert property (!locked |=> pos_act_ff == $past(positive_input_select_ff))
        else $error("active select not copied while unlocked");
    last_unlock_a: assert property (in_conv && tick_cnt_ff == LAST_TICK
        |=> pos_act_ff == $past(positive_input_select_ff) && diff_act_ff == $past(diff_mode_ff))
        else $error("select still locked in last tick");
    neg_gate_a: assert property (!locked && !diff_mode_ff |=> neg_act_ff == NEG_NONE)
        else $error("negative select driven in single-ended mode");
    start_tick_a: assert property (state_ff == ARFM_STARTUP |=> in_conv == $past(adc_tick))
        else $error("conversion began before converter tick");
    start_bound_a: assert property (go |-> ##[1:START_MAX] in_conv)
        else $error("conversion did not begin on next tick");
    start_hold_a: assert property (start_conversion_bit_ff && !done |=> start_conversion_bit_ff)
        else $error("start bit dropped before final sample");
    done_flag_a: assert property (done |=> result_ready_flag_ff && !start_conversion_bit_ff)
        else $error("completion did not set flag or clear start");
    right_one_a: assert property (done && !left_adjust_select_ff && accumulation_count_select_ff == SEL_ONE
        && !diff_mode_ff |=> conversion_result_ff == RESULT_W'($past(acc_ff[SAMPLE_W-1:0])))
        else $error("right adjusted single sample wrong");
    left_two_a: assert property (done && left_adjust_select_ff && accumulation_count_select_ff == SEL_TWO
        |=> conversion_result_ff == {$past(acc_ff[SAMPLE_W:0]), 3'h0})
        else $error("left adjusted two sample result wrong");
    diff_sign_a: assert property (done && diff_mode_ff && !left_adjust_select_ff
        && accumulation_count_select_ff == SEL_ONE
        |=> conversion_result_ff[RESULT_W-1:SAMPLE_W] == {4{conversion_result_ff[SAMPLE_W-1]}})
        else $error("differential result not sign extended");
    trunc_max_a: assert property (done && accumulation_count_select_ff == SEL_MAX
        |=> conversion_result_ff == $past(acc_ff[ACC_W-1:ACC_W-RESULT_W]))
        else $error("truncated sum wrong for largest count");
    sum_add_a: assert property (sample_end |=> acc_ff == ACC_W'($past(acc_ff) + $past(sample_ext)))
        else $error("sample not added to accumulator");
    flag_keep_a: assert property (done && rd_flags |=> result_ready_flag_ff)
        else $error("clearing read lost a completion");

    accum_cov_c: cover property (done && accumulation_count_select_ff == 3'h3);
    left_cov_c: cover property (done && left_adjust_select_ff);
    diff_cov_c: cover property (done && diff_mode_ff);
    lockwr_cov_c: cover property (locked && wr_pos_select);
endmodule

/* File: verification/adc_result_format_mux_tb.sv */
// Self-checking bench for the accumulating result formatter and channel mux
module adc_result_format_mux_tb
    import arfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short converter tick keeps 128-sample runs cheap
    localparam int DIV = 2;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic [SAMPLE_W-1:0] core_sample_data;
    logic [MUX_W-1:0] pos_select_active;
    logic [MUX_W-1:0] neg_select_active;
    logic diff_mode_active;
    logic adc_tick_out;
    logic converting;
    logic irq;
    logic [DATA_W-1:0] rd_val;
    int errors = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    arfm_top #(.ADC_DIV(DIV)) DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sample_data(core_sample_data),
        .pos_select_active(pos_select_active), .neg_select_active(neg_select_active),
        .diff_mode_active(diff_mode_active), .adc_tick_out(adc_tick_out), .converting(converting), .irq(irq));

    arfm_core_model core (.pos_select_active(pos_select_active), .neg_select_active(neg_select_active),
        .diff_mode_active(diff_mode_active), .converting(converting), .core_sample_data(core_sample_data));

    function automatic int lvl(input int ch);
        return 64 * ch + 5;
    endfunction

    // Sum of 2^sel samples, then alignment or truncation
    function automatic logic [DATA_W-1:0] exp_fmt(input int sel, input bit left, input int s);
        int acc;
        acc = s << sel;
        if (sel > 4) acc = acc >>> (sel - 4);
        else if (left) acc = acc << (4 - sel);
        return acc[DATA_W-1:0];
    endfunction

    task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
        logic [DATA_W-1:0] v;
        rd(a, v);
        check(what, exp, v);
    endtask

    // Poll the start bit, bounded well above a 128-sample run
    task automatic wait_done();
        int n = 0;
        rd(ADDR_COMMAND, rd_val);
        while (rd_val[CMD_START_BIT] !== 1'h0 && n < 5000) begin
            rd(ADDR_COMMAND, rd_val);
            n++;
        end
        check("start bit", 16'h0000, rd_val);
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        // About twice the expected run, under the cycle budget
        repeat (60000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        int smp;
        int n;
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        rd_chk(ADDR_RESULT, 16'h0000, "result reset");
        wr(ADDR_RESULT, 16'h1234);
        rd_chk(ADDR_RESULT, 16'h0000, "result read only");
        wr(4'hA, 16'hFFFF);
        rd_chk(4'hA, 16'h0000, "unmapped index");
        // Every mode, alignment and count; diff value is negative to show sign fill
        for (int df = 0; df < 2; df++) begin
            for (int lf = 0; lf < 2; lf++) begin
                for (int sl = 0; sl < 8; sl++) begin
                    wr(ADDR_CONTROL_A, {14'h0000, df[0], lf[0]});
                    wr(ADDR_CONTROL_B, {13'h0000, sl[2:0]});
                    wr(ADDR_POS_SELECT, df ? 16'h0005 : 16'h003F);
                    wr(ADDR_NEG_SELECT, 16'h0020);
                    wr(ADDR_COMMAND, 16'h0001);
                    wait_done();
                    smp = df ? lvl(5) - lvl(32) : lvl(63);
                    rd_chk(ADDR_RESULT, exp_fmt(sl, lf[0], smp), "result");
                    check("irq masked", 16'h0000, {15'h0000, irq});
                    rd_chk(ADDR_INTFLAGS, 16'h0001, "ready flag");
                    rd_chk(ADDR_INTFLAGS, 16'h0000, "flag cleared");
                end
            end
        end
        // Last loop pass left differential mode on, idle so the active copy follows
        check("diff active", 16'h0001, {15'h0000, diff_mode_active});
        wr(ADDR_CONTROL_A, 16'h0000);
        wr(ADDR_CONTROL_B, 16'h0000);
        wr(ADDR_INTMASK, 16'h0001);
        wr(ADDR_NEG_SELECT, 16'h0011);
        wr(ADDR_POS_SELECT, 16'h000A);
        repeat (2) @(posedge clk);
        #1;
        check("pos follows", 16'h000A, {10'h000, pos_select_active});
        check("neg unused", 16'h0000, {10'h000, neg_select_active});
        check("diff idle", 16'h0000, {15'h0000, diff_mode_active});
        check("tick idle", 16'h0000, {15'h0000, adc_tick_out});
        wr(ADDR_COMMAND, 16'h0001);
        repeat (DIV + 2) @(posedge clk);
        #1;
        check("converting", 16'h0001, {15'h0000, converting});
        // Converter tick is a one-cycle pulse every DIV cycles
        n = 0;
        while (adc_tick_out !== 1'h1 && n < DIV) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("tick pulse", 16'h0001, {15'h0000, adc_tick_out});
        @(posedge clk);
        #1;
        check("tick width", 16'h0000, {15'h0000, adc_tick_out});
        rd_chk(ADDR_COMMAND, 16'h0001, "start held");
        wr(ADDR_POS_SELECT, 16'h0015);
        repeat (3) @(posedge clk);
        #1;
        check("pos locked", 16'h000A, {10'h000, pos_select_active});
        n = 0;
        while (pos_select_active !== 6'h15 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("unlock in last tick", 16'h0001, {15'h0000, converting});
        wait_done();
        repeat (2) @(posedge clk);
        #1;
        check("irq raised", 16'h0001, {15'h0000, irq});
        rd_chk(ADDR_INTFLAGS, 16'h0001, "ready flag");
        repeat (2) @(posedge clk);
        #1;
        check("irq cleared", 16'h0000, {15'h0000, irq});
        final_report();
    end
endmodule

/* File: verification/arfm_core_model.sv */
// Behavioural analog core and input mux facing the converter logic
module arfm_core_model
    import arfm_pkg::*;
(
    input wire logic [MUX_W-1:0] pos_select_active,
    input wire logic [MUX_W-1:0] neg_select_active,
    input wire logic diff_mode_active,
    input wire logic converting,
    output logic [SAMPLE_W-1:0] core_sample_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [SAMPLE_W-1:0] conv_val;

    // Channel input level, a fixed ramp so every channel differs
    function automatic int chan_level(input logic [MUX_W-1:0] ch);
        return 64 * int'(ch) + 5;
    endfunction

    // single ended uses positive only, differential is clamped signed
    always_comb begin
        int d;
        d = chan_level(pos_select_active);
        if (diff_mode_active) begin
            d = d - chan_level(neg_select_active);
            if (d > 2047) d = 2047;
            if (d < -2048) d = -2048;
        end
        conv_val = d[SAMPLE_W-1:0];
    end

    // Outside a conversion drive inverted data so stale values never look valid
    assign core_sample_data = converting ? conv_val : ~conv_val;
endmodule
